// File: mac_control_upper_fields_bench.sv
// self-checking bench for the mac control upper fields block
`timescale 1ns/10ps
`default_nettype none
module mac_control_upper_fields_bench import mcuf_pkg::*;;
  typedef struct packed {
    logic [31:0] ctrl;
    logic phyDup;
    logic phyGig;
    logic expDup;
    logic [1:0] expSpd;
    logic expInband;
    logic expRmiiDup;
  } mcuf_row_type;
  logic mclk = 1'b0, rstn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, inbandStatusInput, macFullDuplex;
  logic [1:0] bresp, rresp, descWrWord = 2'h0;
  logic rgmiiDuplexInput, rgmiiSpeedInput, rmiiFullDuplex, rmiiRateTick, descWrGrant, descWrBlocked;
  logic descWrReq = 1'b0, pktDone = 1'b0, rxFifoFlowTrig = 1'b0, linkFull = 1'b0, linkGig = 1'b0;
  logic ownerFlagWrite, ownerFlagValue, pauseSend;
  mcuf_speed_type macLinkSpeed;
  int badCount = 0, checked = 0;
  logic [1:0] resp;
  logic [31:0] data;
  mcuf_row_type rows [7];

  always #4 mclk = ~mclk;

  mcuf_mac_control uut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rgmiiDuplexInput(rgmiiDuplexInput), .rgmiiSpeedInput(rgmiiSpeedInput),
    .inbandStatusInput(inbandStatusInput), .macFullDuplex(macFullDuplex), .macLinkSpeed(macLinkSpeed),
    .rmiiFullDuplex(rmiiFullDuplex), .rmiiRateTick(rmiiRateTick), .descWrReq(descWrReq),
    .descWrWord(descWrWord), .descWrGrant(descWrGrant), .descWrBlocked(descWrBlocked), .pktDone(pktDone),
    .ownerFlagWrite(ownerFlagWrite), .ownerFlagValue(ownerFlagValue), .rxFifoFlowTrig(rxFifoFlowTrig),
    .pauseSend(pauseSend));

  mcuf_phy_model phy (.mclk(mclk), .rstn(rstn), .inbandStatusInput(inbandStatusInput), .linkFull(linkFull),
    .linkGig(linkGig), .rgmiiDuplexInput(rgmiiDuplexInput), .rgmiiSpeedInput(rgmiiSpeedInput));

  // ****************************************
  // compare and closing tasks
  // ****************************************
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finishTest;
    if (badCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // axi4-lite master
  // ****************************************
  // handshakes are judged mid-cycle; registered readies hold until the next rising edge
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
    logic aw, w, b, takeAw, takeW;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge mclk);
      takeAw = aw & awready;
      takeW = w & wready;
      b = bvalid;
      r = bresp;
      @(posedge mclk);
      if (takeAw) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (takeW) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got, takeAr;
    ar = 1'b1;
    got = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge mclk);
      takeAr = ar & arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (takeAr) begin
        arvalid <= 1'b0;
        ar = 1'b0;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one request cycle on the dma and flow-control inputs
  task automatic sidePulse(input logic [1:0] word, input logic trig);
    @(posedge mclk);
    descWrReq <= 1'b1;
    descWrWord <= word;
    pktDone <= 1'b1;
    rxFifoFlowTrig <= trig;
    @(posedge mclk);
    descWrReq <= 1'b0;
    pktDone <= 1'b0;
    rxFifoFlowTrig <= 1'b0;
    #1;
  endtask

  task automatic tickGap(input int exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (!rmiiRateTick && n < 200);
    end
    checkWord(32'(n), 32'(exp));
  endtask

  initial begin
    #160000;
    badCount++;
    finishTest();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows[0] = {32'h0000_0000, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0};
    rows[1] = {32'h0000_0081, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0};
    rows[2] = {32'h0004_0000, 1'b1, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0};
    rows[3] = {32'h0004_0081, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0};
    rows[4] = {32'h0002_0000, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0};
    rows[5] = {32'h0001_0001, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1};
    rows[6] = {32'h0006_8000, 1'b1, 1'b0, 1'b1, 2'h2, 1'b1, 1'b0};
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    axiRead(CTRL_OFFSET, data, resp);
    checkWord(data, 32'h0);
    axiRead(STAT_OFFSET, data, resp);
    checkWord(data, 32'h2);
    foreach (rows[i]) begin
      linkFull <= rows[i].phyDup;
      linkGig <= rows[i].phyGig;
      axiWrite(CTRL_OFFSET, rows[i].ctrl, 4'hf, resp);
      settle(4);
      checkBit(macFullDuplex, rows[i].expDup);
      checkWord(32'(macLinkSpeed), 32'(rows[i].expSpd));
      checkBit(inbandStatusInput, rows[i].expInband);
      checkBit(rmiiFullDuplex, rows[i].expRmiiDup);
      axiRead(STAT_OFFSET, data, resp);
      checkWord(data, {28'h0, rows[i].expInband, rows[i].expSpd, rows[i].expDup});
    end
    // reserved bits and byte strobes
    axiWrite(CTRL_OFFSET, 32'hffff_ffff, 4'hf, resp);
    axiRead(CTRL_OFFSET, data, resp);
    checkWord(data, 32'h0007_f081);
    axiWrite(CTRL_OFFSET, 32'h0, 4'hf, resp);
    axiWrite(CTRL_OFFSET, 32'hffff_ffff, 4'h2, resp);
    axiRead(CTRL_OFFSET, data, resp);
    checkWord(data, 32'h0000_f000);
    // unmapped place
    axiWrite(4'h8, 32'hffff_ffff, 4'hf, resp);
    checkWord(32'(resp), 32'(RESP_DECERR));
    axiRead(4'h8, data, resp);
    checkWord({data[29:0], resp}, {30'h0, RESP_DECERR});
    // rmii rate
    axiWrite(CTRL_OFFSET, 32'h0000_8000, 4'hf, resp);
    tickGap(5);
    axiWrite(CTRL_OFFSET, 32'h0, 4'hf, resp);
    tickGap(50);
    // descriptor writes, ownership and pause
    for (int i = 0; i < 2; i++) begin
      axiWrite(CTRL_OFFSET, (i == 1) ? 32'h0000_7001 : 32'h0000_0001, 4'hf, resp);
      settle(3);
      sidePulse(DESC_OFFLEN_WORD, 1'b1);
      checkBit(descWrGrant, i == 0);
      checkBit(descWrBlocked, i == 1);
      checkBit(ownerFlagWrite, 1'b1);
      checkBit(ownerFlagValue, i == 1);
      checkBit(pauseSend, i == 1);
    end
    sidePulse(2'h1, 1'b0);
    checkBit(descWrGrant, 1'b1);
    checkBit(pauseSend, 1'b0);
    // pause enabled but half duplex
    axiWrite(CTRL_OFFSET, 32'h0000_1000, 4'hf, resp);
    settle(3);
    sidePulse(2'h0, 1'b1);
    checkBit(pauseSend, 1'b0);
    // reset in mid-run
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    axiRead(CTRL_OFFSET, data, resp);
    checkWord(data, 32'h0);
    finishTest();
  end
endmodule
`default_nettype wire

// File: mcuf_link_mode.sv
// rgmii duplex and speed resolution
`timescale 1ns/10ps
`default_nettype none
module mcuf_link_mode import mcuf_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic inbandSel,
  input wire logic forcedDuplex,
  input wire logic forcedGig,
  input wire logic gigabit_force_bit,
  input wire logic rgmiiDuplexInput,
  input wire logic rgmiiSpeedInput,
  output logic fullDuplex,
  output var mcuf_speed_type linkSpeed
);

  logic duplexSel;
  logic gigSel;

  // inband source or forced bits; forced mode knows only 1g or 100m
  assign duplexSel = inbandSel ? rgmiiDuplexInput : forcedDuplex;
  assign gigSel = gigabit_force_bit | (inbandSel ? rgmiiSpeedInput : forcedGig);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fullDuplex <= 1'b0;
      linkSpeed <= MCUF_SPD_100;
    end else begin
      fullDuplex <= duplexSel;
      linkSpeed <= gigSel ? MCUF_SPD_1000 : MCUF_SPD_100;
    end
  end

endmodule
`default_nettype wire

// File: mcuf_mac_control.sv
// mac control upper fields with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RQ1] inband select set: duplex and gigabit follow the rgmii input pins
// [RQ2] inband select bit drives the rgmii inband status input directly
// [RQ3] inband select clear: forced duplex and speed bits, 1g or 100m only
// [RQ4] inband select set: rgmii side uses inband status from its receive path
// [RQ5] gigabit force bit puts the mac in gigabit even without transmit clock
// [RQ6] rmii duplex bit: 0 half duplex, 1 full duplex
// [RQ7] rmii speed bit: 0 gives 10m at 2.5 mhz, 1 gives 100m at 25 mhz
// [RQ8] offset length block set: no descriptor third word writes
// [RQ9] offset length block clear: third word writes pass normally
// [RQ10] ownership value 0: ownership flag written as zero at packet end
// [RQ11] ownership value 1: ownership flag written as one at packet end
// [RQ12] software not using ownership handshake should set ownership value
// [RQ13] pause enable clear: no pause frames in full duplex
// [RQ14] pause enable set in full duplex: pause frame on fifo trigger
// [RQ15] reserved bits 31 to 19 read zero and ignore writes
module mcuf_mac_control import mcuf_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rgmiiDuplexInput,
  input wire logic rgmiiSpeedInput,
  output logic inbandStatusInput,
  output logic macFullDuplex,
  output var mcuf_speed_type macLinkSpeed,
  output logic rmiiFullDuplex,
  output logic rmiiRateTick,
  input wire logic descWrReq,
  input wire logic [1:0] descWrWord,
  output logic descWrGrant,
  output logic descWrBlocked,
  input wire logic pktDone,
  output logic ownerFlagWrite,
  output logic ownerFlagValue,
  input wire logic rxFifoFlowTrig,
  output logic pauseSend
);

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic awFire;
  logic wFire;
  logic wrFire;
  logic bFire;
  logic arFire;
  logic rFire;
  mcuf_regsel_type wrSel;
  mcuf_regsel_type rdSel;
  logic [31:0] statWord;
  logic [31:0] rdWord;
  logic descBlockHit;

  // ****************************************
  // axi4-lite write path
  // ****************************************
  assign awFire = awvalid && awready;
  assign wFire = wvalid && wready;
  assign wrFire = awHeld_reg && wHeld_reg && !bvalid;
  assign bFire = bvalid && bready;
  assign wrSel = regSelect(awAddr_reg);

  // reserved bits masked off on every write
  // [RQ15] reserved write ignore
  assign ctrl_next = (wrFire && wrSel == MCUF_SEL_CTRL)
                   ? (mergeBytes(ctrl_reg, wData_reg, wStrb_reg) & CTRL_WMASK) : ctrl_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      awHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
    end else begin
      if (awFire) begin
        awready <= 1'b0;
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end else if (bFire) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wready <= 1'b1;
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (wFire) begin
        wready <= 1'b0;
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end else if (bFire) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= (wrSel == MCUF_SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end else if (bFire) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  assign arFire = arvalid && arready;
  assign rFire = rvalid && rready;
  assign rdSel = regSelect(araddr);
  assign statWord = {28'h0000000, inbandStatusInput, macLinkSpeed, macFullDuplex};
  // [RQ15] reserved read zero
  assign rdWord = (rdSel == MCUF_SEL_CTRL) ? ctrl_reg
                : (rdSel == MCUF_SEL_STAT) ? statWord : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      if (arFire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdWord;
        rresp <= (rdSel == MCUF_SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end else if (rFire) begin
        arready <= 1'b1;
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // link mode and rmii rate
  // ****************************************
  // [RQ1] inband source select
  // [RQ3] forced link mode
  // [RQ4] inband status use
  // [RQ5] gigabit force override
  mcuf_link_mode linkMode (
    .mclk(mclk),
    .rstn(rstn),
    .inbandSel(ctrl_reg[BIT_INBAND_SEL]),
    .forcedDuplex(ctrl_reg[BIT_FORCED_DUPLEX]),
    .forcedGig(ctrl_reg[BIT_FORCED_GIG]),
    .gigabit_force_bit(ctrl_reg[BIT_GIG_FORCE]),
    .rgmiiDuplexInput(rgmiiDuplexInput),
    .rgmiiSpeedInput(rgmiiSpeedInput),
    .fullDuplex(macFullDuplex),
    .linkSpeed(macLinkSpeed)
  );

  // [RQ7] rmii rate select
  mcuf_rmii_tick rmiiTick (
    .mclk(mclk),
    .rstn(rstn),
    .speedSel(ctrl_reg[BIT_RMII_SPEED]),
    .rateTick(rmiiRateTick)
  );

  // [RQ2] inband bit straight out
  assign inbandStatusInput = ctrl_reg[BIT_INBAND_SEL];
  // [RQ6] rmii duplex straight out
  assign rmiiFullDuplex = ctrl_reg[BIT_RMII_DUPLEX];

  // ****************************************
  // descriptor writeback and pause
  // ****************************************
  assign descBlockHit = ctrl_reg[BIT_OFFLEN_BLOCK] && descWrWord == DESC_OFFLEN_WORD;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      descWrGrant <= 1'b0;
      descWrBlocked <= 1'b0;
      ownerFlagWrite <= 1'b0;
      ownerFlagValue <= 1'b0;
      pauseSend <= 1'b0;
    end else begin
      // [RQ8] third word suppress
      // [RQ9] normal word pass
      descWrGrant <= descWrReq && !descBlockHit;
      descWrBlocked <= descWrReq && descBlockHit;
      // [RQ10] owner value zero
      // [RQ11] owner value one
      ownerFlagWrite <= pktDone;
      ownerFlagValue <= ctrl_reg[BIT_OWNER_VALUE];
      // [RQ13] pause disabled
      // [RQ14] pause on trigger
      pauseSend <= rxFifoFlowTrig && ctrl_reg[BIT_PAUSE_EN] && macFullDuplex;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  localparam int FastGap = RMII_FAST_DIV - 1;
  localparam int SlowGap = RMII_SLOW_DIV - 1;
  logic [7:0] gapCnt_reg;
  logic gapDirty_reg;
  logic spdPrev_reg;
  logic spdChg;

  assign spdChg = ctrl_reg[BIT_RMII_SPEED] != spdPrev_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_reg <= 8'h00;
      gapDirty_reg <= 1'b1;
      spdPrev_reg <= 1'b0;
    end else begin
      gapCnt_reg <= rmiiRateTick ? 8'h00 : gapCnt_reg + 8'h01;
      gapDirty_reg <= spdChg ? 1'b1 : (rmiiRateTick ? 1'b0 : gapDirty_reg);
      spdPrev_reg <= ctrl_reg[BIT_RMII_SPEED];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence ctrlWrite;
    wrFire && wrSel == MCUF_SEL_CTRL;
  endsequence

  sequence ctrlWriteLane2;
    ctrlWrite ##0 wStrb_reg[2];
  endsequence

  sequence ctrlWriteLane1;
    ctrlWrite ##0 wStrb_reg[1];
  endsequence

  sequence ctrlRead;
    arFire && rdSel == MCUF_SEL_CTRL;
  endsequence

  inband_direct_a: assert property (ctrlWriteLane2 |=> ##1 inbandStatusInput == $past(wData_reg[18], 2)) // [RQ2]
    else $error("inband status does not follow written bit");

  inband_duplex_a: assert property ($past(ctrl_reg[18]) |-> macFullDuplex == $past(rgmiiDuplexInput)) // [RQ1]
    else $error("inband duplex not taken from pin");

  inband_speed_a: assert property ($past(ctrl_reg[18] && !ctrl_reg[17])
                                   |-> (macLinkSpeed == MCUF_SPD_1000) == $past(rgmiiSpeedInput)) // [RQ4]
    else $error("inband speed not taken from pin");

  forced_mode_a: assert property ($past(!ctrl_reg[18] && !ctrl_reg[17])
                                  |-> macFullDuplex == $past(ctrl_reg[0])
                                  && macLinkSpeed == ($past(ctrl_reg[7]) ? MCUF_SPD_1000 : MCUF_SPD_100)) // [RQ3]
    else $error("forced link mode wrong");

  gig_force_a: assert property ($past(ctrl_reg[17]) |-> macLinkSpeed == MCUF_SPD_1000) // [RQ5]
    else $error("gigabit force ignored");

  rmii_duplex_a: assert property (ctrlWriteLane2 |=> ##1 rmiiFullDuplex == $past(wData_reg[16], 2)) // [RQ6]
    else $error("rmii duplex not following write");

  rmii_rate_a: assert property (rmiiRateTick && !gapDirty_reg
                                |-> gapCnt_reg == (ctrl_reg[15] ? 8'(FastGap) : 8'(SlowGap))) // [RQ7]
    else $error("rmii tick spacing wrong");

  offlen_block_a: assert property (descWrReq && descWrWord == 2'h2 && ctrl_reg[14]
                                   |=> !descWrGrant && descWrBlocked) // [RQ8]
    else $error("offset length write not blocked");

  offlen_pass_a: assert property (descWrReq && !ctrl_reg[14] |=> descWrGrant && !descWrBlocked) // [RQ9]
    else $error("descriptor write wrongly blocked");

  owner_zero_a: assert property (pktDone && !ctrl_reg[13] |=> ownerFlagWrite && !ownerFlagValue) // [RQ10]
    else $error("ownership flag not zero");

  owner_one_a: assert property (pktDone && ctrl_reg[13] |=> ownerFlagWrite && ownerFlagValue) // [RQ11]
    else $error("ownership flag not one");

  pause_off_a: assert property (!ctrl_reg[12] |=> !pauseSend) // [RQ13]
    else $error("pause sent while disabled");

  pause_on_a: assert property (rxFifoFlowTrig && ctrl_reg[12] && macFullDuplex |=> pauseSend) // [RQ14]
    else $error("pause not sent on trigger");

  rsvd_read_a: assert property (ctrlRead |=> rvalid && rdata[31:19] == 13'h0000) // [RQ15]
    else $error("reserved bits read nonzero");

  rsvd_write_a: assert property (ctrlWriteLane1 |=> ctrl_reg[31:19] == 13'h0000 && ctrl_reg[11:8] == 4'h0) // [RQ15]
    else $error("reserved write took effect");

  write_resp_a: assert property (wrFire |=> bvalid ##0 (bvalid throughout (!awready [*1])))
    else $error("write response missing");

endmodule
`default_nettype wire

// File: mcuf_phy_model.sv
// behavioural phy model driving the rgmii in-band status pins
`timescale 1ns/10ps
`default_nettype none
module mcuf_phy_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic inbandStatusInput,
  input wire logic linkFull,
  input wire logic linkGig,
  output logic rgmiiDuplexInput,
  output logic rgmiiSpeedInput
);
  // ****************************************
  // in-band status drive
  // ****************************************
  // status only when requested
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rgmiiDuplexInput <= 1'b0;
      rgmiiSpeedInput <= 1'b0;
    end else if (inbandStatusInput) begin
      rgmiiDuplexInput <= linkFull;
      rgmiiSpeedInput <= linkGig;
    end else begin
      // no valid status: pins toggle so forced mode must ignore them
      rgmiiDuplexInput <= ~rgmiiDuplexInput;
      rgmiiSpeedInput <= ~rgmiiSpeedInput;
    end
  end
endmodule
`default_nettype wire

// File: mcuf_pkg.sv
// constants and types for the mac control upper fields block
package mcuf_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_f081;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int unsigned BIT_INBAND_SEL = 18;
  localparam int unsigned BIT_GIG_FORCE = 17;
  localparam int unsigned BIT_RMII_DUPLEX = 16;
  localparam int unsigned BIT_RMII_SPEED = 15;
  localparam int unsigned BIT_OFFLEN_BLOCK = 14;
  localparam int unsigned BIT_OWNER_VALUE = 13;
  localparam int unsigned BIT_PAUSE_EN = 12;
  localparam int unsigned BIT_FORCED_GIG = 7;
  localparam int unsigned BIT_FORCED_DUPLEX = 0;

  // ****************************************
  // descriptor and timing
  // ****************************************
  localparam logic [1:0] DESC_OFFLEN_WORD = 2'h2;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned RMII_FAST_HZ = 25000000;
  localparam int unsigned RMII_SLOW_HZ = 2500000;
  localparam int unsigned RMII_FAST_DIV = CLK_HZ / RMII_FAST_HZ;
  localparam int unsigned RMII_SLOW_DIV = CLK_HZ / RMII_SLOW_HZ;

  typedef enum logic [1:0] {MCUF_SPD_10, MCUF_SPD_100, MCUF_SPD_1000} mcuf_speed_type;
  typedef enum logic [1:0] {MCUF_SEL_CTRL, MCUF_SEL_STAT, MCUF_SEL_NONE} mcuf_regsel_type;

  // register select from a byte address
  function automatic mcuf_regsel_type regSelect(input logic [3:0] addr);
    mcuf_regsel_type sel;
    sel = MCUF_SEL_NONE;
    if (addr == CTRL_OFFSET) begin
      sel = MCUF_SEL_CTRL;
    end else if (addr == STAT_OFFSET) begin
      sel = MCUF_SEL_STAT;
    end
    return sel;
  endfunction

  // byte lane merge under strobes
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// File: mcuf_rmii_tick.sv
// rmii rate tick generator
`timescale 1ns/10ps
`default_nettype none
module mcuf_rmii_tick import mcuf_pkg::*; #(
  parameter int unsigned FAST_DIV = RMII_FAST_DIV,
  parameter int unsigned SLOW_DIV = RMII_SLOW_DIV
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic speedSel,
  output logic rateTick
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic spd_reg;
  logic restart;
  logic [7:0] limit;

  assign limit = speedSel ? 8'(FAST_DIV - 1) : 8'(SLOW_DIV - 1);
  assign restart = speedSel != spd_reg;
  assign cnt_next = (restart || cnt_reg == limit) ? 8'h00 : cnt_reg + 8'h01;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
      spd_reg <= 1'b0;
      rateTick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      spd_reg <= speedSel;
      rateTick <= !restart && cnt_reg == limit;
    end
  end

endmodule
`default_nettype wire
